// ==== rtl/qdlpc_top.sv ====
// Command decode, load strobe, power-mode and reference control of a quad converter.
// Assumes a framed 24-bit command word with a one-cycle valid strobe, all pins synchronous.
//
// What this block does
// - 24-bit word: code, selects, data
// - Writes and updates act on selected channels
// - Code 0100 sets power modes from DB7:0
// - Two-bit mode: normal, 1k, 100k, three-state
// - Channel D high pair down to A
// - Power-down ignores selects and DB15:8
// - Power-down keeps and still updates output
// - Strobe low: 0001 loads input and output
// - Strobe high: 0001 input only, fall loads
// - Code 0010 copies input to output
// - Code 0011 writes input and output
// - Code 0101 loads mask from DB3:0
// - Mask resets zero; one ignores strobe
// - Strobe fall copies unmasked channels
// - Strobe tied low disregards mask
// - Hardware reset clears to select level
// - No output update while reset low
// - Code 0110 acts as power-on reset
// - Power-on sequence ignores strobe, reset pins
// - Power-up level from select pin, held
// - Code 0111 sets reference bit DB0
`timescale 1ns/100ps
`default_nettype none
module qdlpc_top
    import qdlpc_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    resetn,
    input  wire logic                    cmd_valid,
    input  wire logic [CMD_W-1:0]        cmd_word,
    input  wire logic                    load_strobe_pin,
    input  wire logic                    hw_reset_n_pin,
    input  wire logic                    reset_level_select,
    output logic      [NCHAN*DATA_W-1:0] out_code,
    output logic      [NCHAN*DATA_W-1:0] in_code,
    output logic      [MODE_W-1:0]       channel_power_mode,
    output logic      [MASK_W-1:0]       load_strobe_mask,
    output logic                         reference_off,
    output logic                         por_busy
);
    logic [3:0]              code;
    logic [NCHAN-1:0]        sel;
    logic [DATA_W-1:0]       data;
    logic                    strobe_fall;
    logic                    por_active;
    logic                    hw_clear;
    logic                    any_clear;
    logic [DATA_W-1:0]       clr_code;
    logic [4:0]              por_cnt_reg;
    logic [4:0]              por_cnt_next;
    logic                    por_sw;
    logic [MODE_W-1:0]       mode_reg;
    logic [MODE_W-1:0]       mode_next;
    logic [MASK_W-1:0]       mask_reg;
    logic [MASK_W-1:0]       mask_next;
    logic                    ref_reg;
    logic                    ref_next;
    logic [NCHAN*DATA_W-1:0] in_w;
    logic [NCHAN*DATA_W-1:0] out_w;
    logic [NCHAN*DATA_W-1:0] in_reg;
    logic [NCHAN*DATA_W-1:0] out_reg;
    logic                    por_busy_reg;

    // Command fields
    assign code = cmd_word[CODE_MSB:CODE_LSB];
    assign sel  = cmd_word[SEL_MSB:SEL_LSB];
    assign data = cmd_word[DATA_MSB:DATA_LSB];

    function automatic logic is_cmd(input logic v, input logic [3:0] c, input qdlpc_cmd_t k);
        is_cmd = v && (c == k);
    endfunction

    // Power-on sequence: restarted by reset and by the software reset command
    assign por_sw       = is_cmd(cmd_valid, code, QDLPC_SW_RST);
    assign por_active   = (por_cnt_reg != 5'h00);
    assign por_cnt_next = por_sw ? POR_CNT_W : (por_active ? por_cnt_reg - 5'h01 : por_cnt_reg);

    always_ff @(posedge clk) begin
        if (!resetn) por_cnt_reg <= POR_CNT_W;
        else         por_cnt_reg <= por_cnt_next;
    end

    // Pin reset is ignored during power-on sequence, which clears anyway
    assign hw_clear  = ~hw_reset_n_pin & ~por_active;
    assign any_clear = por_active | hw_clear;
    assign clr_code  = reset_level_select ? MID_CODE : ZERO_CODE;

    qdlpc_edge u_qdlpc_edge (
        .clk    (clk),
        .resetn (resetn),
        .pin    (load_strobe_pin),
        .fall   (strobe_fall)
    );

    // Per-channel data path; strobe low passes a 0001 write to the output, otherwise only its fall loads
    generate
        for (genvar i = 0; i < NCHAN; i++) begin : g_chan
            logic wr_in_c;
            logic wr_out_c;
            logic copy_c;
            logic ok;
            // Updates blocked under reset and power-on
            assign ok       = cmd_valid & sel[i] & ~any_clear;
            assign wr_in_c  = ok & ((code == QDLPC_WR_IN) | (code == QDLPC_WR_UPD));
            // Strobe low: transparent, mask disregarded
            assign wr_out_c = (ok & (code == QDLPC_WR_UPD))
                            | (ok & (code == QDLPC_WR_IN) & ~load_strobe_pin);
            assign copy_c   = (ok & (code == QDLPC_UPD_OUT))
                            | (strobe_fall & ~mask_reg[i] & ~any_clear);
            qdlpc_chan u_qdlpc_chan (
                .clk      (clk),
                .wr_in    (wr_in_c),
                .wr_out   (wr_out_c),
                .copy     (copy_c),
                .clear    (any_clear),
                .clr_code (clr_code),
                .data     (data),
                .in_q     (in_w[i*DATA_W +: DATA_W]),
                .out_q    (out_w[i*DATA_W +: DATA_W])
            );
        end
    endgenerate

    // Mode bits: D in DB7:6 down to A in DB1:0; selects and DB15:8 unused
    assign mode_next = por_active ? MODE_RST :
                       (is_cmd(cmd_valid, code, QDLPC_PWR_MODE) ? cmd_word[MODE_W-1:0] : mode_reg);
    assign mask_next = por_active ? MASK_RST :
                       (is_cmd(cmd_valid, code, QDLPC_MASK) ? cmd_word[MASK_W-1:0] : mask_reg);
    assign ref_next  = por_active ? REF_RST :
                       (is_cmd(cmd_valid, code, QDLPC_REF) ? cmd_word[0] : ref_reg);

    // Control registers; unknown codes fall through unchanged
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mode_reg <= MODE_RST;
            mask_reg <= MASK_RST;
            ref_reg  <= REF_RST;
        end else begin
            mode_reg <= mode_next;
            mask_reg <= mask_next;
            ref_reg  <= ref_next;
        end
    end

    // Outputs registered; mode changes do not touch the code registers
    always_ff @(posedge clk) begin
        in_reg       <= in_w;
        out_reg      <= out_w;
        por_busy_reg <= resetn ? por_active : 1'b1;
    end

    assign out_code           = out_reg;
    assign in_code            = in_reg;
    assign channel_power_mode = mode_reg;
    assign load_strobe_mask   = mask_reg;
    assign reference_off      = ref_reg;
    assign por_busy           = por_busy_reg;

    // Checks
    property p_wr_upd;
        @(posedge clk) disable iff (!resetn)
        (cmd_valid && code == 4'h3 && sel[0] && !any_clear) |-> ##2 out_code[DATA_W-1:0] == $past(data, 2);
    endproperty
    a_wr_upd: assert property (p_wr_upd) else $error("write-update lost");

    property p_deferred;
        @(posedge clk) disable iff (!resetn)
        (cmd_valid && code == 4'h1 && sel[0] && load_strobe_pin && !any_clear && !strobe_fall)
            |-> ##2 out_code[DATA_W-1:0] == $past(out_w[DATA_W-1:0], 2);
    endproperty
    a_deferred: assert property (p_deferred) else $error("deferred write reached output");

    property p_pwr;
        @(posedge clk) disable iff (!resetn)
        (cmd_valid && code == 4'h4 && !por_active) |=> mode_reg == $past(cmd_word[7:0]);
    endproperty
    a_pwr: assert property (p_pwr) else $error("power mode not loaded");

    property p_mask;
        @(posedge clk) disable iff (!resetn)
        (cmd_valid && code == 4'h5 && !por_active) |=> mask_reg == $past(cmd_word[3:0]);
    endproperty
    a_mask: assert property (p_mask) else $error("mask not loaded");

    property p_ref;
        @(posedge clk) disable iff (!resetn)
        (cmd_valid && code == 4'h7 && !por_active) |=> reference_off == $past(cmd_word[0]);
    endproperty
    a_ref: assert property (p_ref) else $error("reference bit wrong");

    property p_hwrst;
        @(posedge clk) disable iff (!resetn)
        (!hw_reset_n_pin && !por_active) |-> ##2 out_code[DATA_W-1:0] == $past(clr_code, 2);
    endproperty
    a_hwrst: assert property (p_hwrst) else $error("reset level wrong");

    property p_nop;
        @(posedge clk) disable iff (!resetn)
        (cmd_valid && (code == 4'h0 || code[3]) && !por_active && !hw_clear && !strobe_fall)
            |=> $stable(mode_reg) && $stable(mask_reg) && $stable(ref_reg) && $stable(out_w) && $stable(in_w);
    endproperty
    a_nop: assert property (p_nop) else $error("reserved code changed state");

    property p_swrst;
        @(posedge clk) disable iff (!resetn)
        (cmd_valid && code == 4'h6) |=> por_active [*8];
    endproperty
    a_swrst: assert property (p_swrst) else $error("software reset not held");

    // Strobe low makes a plain input write reach the output at once
    property p_wr_in_low;
        @(posedge clk) disable iff (!resetn)
        (cmd_valid && code == QDLPC_WR_IN && sel[0] && !load_strobe_pin && !any_clear)
            |-> ##2 out_code[DATA_W-1:0] == $past(data, 2);
    endproperty
    a_wr_in_low: assert property (p_wr_in_low) else $error("transparent write missed output");

    property p_in_wr;
        @(posedge clk) disable iff (!resetn)
        (cmd_valid && (code == QDLPC_WR_IN || code == QDLPC_WR_UPD) && sel[0] && !any_clear)
            |-> ##2 in_code[DATA_W-1:0] == $past(data, 2);
    endproperty
    a_in_wr: assert property (p_in_wr) else $error("input register not written");

    property p_unsel;
        @(posedge clk) disable iff (!resetn)
        (cmd_valid && code == QDLPC_WR_UPD && !sel[NCHAN-1] && !any_clear && !strobe_fall)
            |=> $stable(in_w[NCHAN*DATA_W-1 -: DATA_W]) && $stable(out_w[NCHAN*DATA_W-1 -: DATA_W]);
    endproperty
    a_unsel: assert property (p_unsel) else $error("unselected channel changed");

    property p_upd;
        @(posedge clk) disable iff (!resetn)
        (cmd_valid && code == QDLPC_UPD_OUT && sel[1] && !any_clear)
            |=> out_w[2*DATA_W-1 -: DATA_W] == $past(in_w[2*DATA_W-1 -: DATA_W]) && $stable(in_w);
    endproperty
    a_upd: assert property (p_upd) else $error("update did not copy input");

    // Channel B unmasked, channel A masked in the bench traffic
    property p_fall;
        @(posedge clk) disable iff (!resetn)
        (strobe_fall && !mask_reg[1] && !cmd_valid && !any_clear)
            |=> out_w[2*DATA_W-1 -: DATA_W] == $past(in_w[2*DATA_W-1 -: DATA_W]);
    endproperty
    a_fall: assert property (p_fall) else $error("strobe fall did not load");

    property p_masked;
        @(posedge clk) disable iff (!resetn)
        (strobe_fall && mask_reg[0] && !cmd_valid && !any_clear) |=> $stable(out_w[DATA_W-1:0]);
    endproperty
    a_masked: assert property (p_masked) else $error("masked channel loaded");

    property p_hw_block;
        @(posedge clk) disable iff (!resetn)
        (!hw_reset_n_pin && cmd_valid) |=> out_w == {NCHAN{$past(clr_code)}};
    endproperty
    a_hw_block: assert property (p_hw_block) else $error("write passed hardware clear");

    property p_por_clr;
        @(posedge clk) disable iff (!resetn)
        por_active |=> out_w == {NCHAN{$past(clr_code)}} && in_w == {NCHAN{$past(clr_code)}};
    endproperty
    a_por_clr: assert property (p_por_clr) else $error("power-on level wrong");

    property p_por_ctl;
        @(posedge clk) disable iff (!resetn)
        por_active |=> mode_reg == MODE_RST && mask_reg == MASK_RST && ref_reg == REF_RST;
    endproperty
    a_por_ctl: assert property (p_por_ctl) else $error("control not at power-on value");

    property p_ref_hold;
        @(posedge clk) disable iff (!resetn)
        (reference_off && !(cmd_valid && code == QDLPC_REF) && !por_active) |=> reference_off;
    endproperty
    a_ref_hold: assert property (p_ref_hold) else $error("reference came back on");

    property p_mode_keep;
        @(posedge clk) disable iff (!resetn)
        (cmd_valid && code == QDLPC_PWR_MODE && !any_clear && !strobe_fall)
            |=> $stable(out_w) && $stable(in_w);
    endproperty
    a_mode_keep: assert property (p_mode_keep) else $error("power mode touched codes");

    property p_busy;
        @(posedge clk) disable iff (!resetn)
        por_busy == $past(por_active);
    endproperty
    a_busy: assert property (p_busy) else $error("busy flag out of step");

    property p_pwr_other;
        @(posedge clk) disable iff (!resetn)
        (cmd_valid && code == QDLPC_PWR_MODE && !por_active) |=> $stable(mask_reg) && $stable(ref_reg);
    endproperty
    a_pwr_other: assert property (p_pwr_other) else $error("power command hit other register");

    property p_mode_d;
        @(posedge clk) disable iff (!resetn)
        (cmd_valid && code == QDLPC_PWR_MODE && !por_active)
            |=> channel_power_mode[MODE_W-1 -: 2] == $past(cmd_word[7:6]);
    endproperty
    a_mode_d: assert property (p_mode_d) else $error("channel D mode misplaced");

    // Codes stand until a command, a strobe fall or a clear
    property p_stand;
        @(posedge clk) disable iff (!resetn)
        (!cmd_valid && !strobe_fall && !any_clear) |=> $stable(out_w) && $stable(in_w);
    endproperty
    a_stand: assert property (p_stand) else $error("code changed without cause");
endmodule
`default_nettype wire

// ==== include/qdlpc_pkg.sv ====
// Shared constants for the quad converter load and power-down control.
// Assumes a single 250 MHz clock domain; command words arrive already framed.
package qdlpc_pkg;
    localparam int CMD_W       = 24;
    localparam int CODE_MSB    = 23;
    localparam int CODE_LSB    = 20;
    localparam int SEL_MSB     = 19;
    localparam int SEL_LSB     = 16;
    localparam int DATA_MSB    = 15;
    localparam int DATA_LSB    = 0;
    localparam int NCHAN       = 4;
    localparam int DATA_W      = 16;
    localparam int MODE_W      = 8;
    localparam int MASK_W      = 4;

    typedef enum logic [3:0] {
        QDLPC_NOP      = 4'h0,
        QDLPC_WR_IN    = 4'h1,
        QDLPC_UPD_OUT  = 4'h2,
        QDLPC_WR_UPD   = 4'h3,
        QDLPC_PWR_MODE = 4'h4,
        QDLPC_MASK     = 4'h5,
        QDLPC_SW_RST   = 4'h6,
        QDLPC_REF      = 4'h7
    } qdlpc_cmd_t;

    typedef enum logic [1:0] {
        QDLPC_PWR_UP   = 2'h0,
        QDLPC_PWR_1K   = 2'h1,
        QDLPC_PWR_100K = 2'h2,
        QDLPC_PWR_TRI  = 2'h3
    } qdlpc_pmode_t;

    localparam logic [MODE_W-1:0] MODE_RST   = 8'h00;
    localparam logic [MASK_W-1:0] MASK_RST   = 4'h0;
    localparam logic              REF_RST    = 1'b0;
    localparam logic [DATA_W-1:0] ZERO_CODE  = 16'h0000;
    localparam logic [DATA_W-1:0] MID_CODE   = 16'h8000;
    // Power-on reset length in clock cycles
    localparam int                POR_CYCLES = 16;
    localparam logic [4:0]        POR_CNT_W  = 5'h10;
endpackage

// ==== rtl/qdlpc_edge.sv ====
// Falling-edge detector for the load strobe pin.
// Assumes the pin is already synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module qdlpc_edge (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic pin,
    output logic      fall
);
    logic last_reg;

    // Last pin level; reset high so a pin idling high never fakes an edge
    always_ff @(posedge clk) begin
        if (!resetn) last_reg <= 1'b1;
        else         last_reg <= pin;
    end

    assign fall = last_reg & ~pin;
endmodule
`default_nettype wire

// ==== rtl/qdlpc_chan.sv ====
// One channel: input register and output register with load control.
// Assumes the top decodes commands and supplies the reset code.
`timescale 1ns/100ps
`default_nettype none
module qdlpc_chan
    import qdlpc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              wr_in,
    input  wire logic              wr_out,
    input  wire logic              copy,
    input  wire logic              clear,
    input  wire logic [DATA_W-1:0] clr_code,
    input  wire logic [DATA_W-1:0] data,
    output logic      [DATA_W-1:0] in_q,
    output logic      [DATA_W-1:0] out_q
);
    logic [DATA_W-1:0] in_reg;
    logic [DATA_W-1:0] out_reg;
    logic [DATA_W-1:0] in_next;
    logic [DATA_W-1:0] out_next;

    // Direct data write beats a copy of the stale input register
    assign in_next  = clear ? clr_code : (wr_in ? data : in_reg);
    assign out_next = clear ? clr_code : (wr_out ? data : (copy ? in_reg : out_reg));

    // Clear drives both registers so a later copy stays at reset level
    always_ff @(posedge clk) begin
        in_reg  <= in_next;
        out_reg <= out_next;
    end

    assign in_q  = in_reg;
    assign out_q = out_reg;
endmodule
`default_nettype wire

// ==== tb/qdlpc_host.sv ====
// Host model: hands framed 24-bit command words to the block, one valid pulse each.
// Assumes the bench asks with a one-cycle send and picks a lag of 0 to 3 cycles.
`timescale 1ns/100ps
`default_nettype none
module qdlpc_host
    import qdlpc_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             send,
    input  wire logic [1:0]       lag,
    input  wire logic [CMD_W-1:0] word,
    output logic                  cmd_valid,
    output logic      [CMD_W-1:0] cmd_word
);
    logic [2:0]       wait_reg;
    logic [CMD_W-1:0] hold_reg;

    // Word goes out after the lag; between words the bus toggles, never stale
    always_ff @(posedge clk) begin
        cmd_valid <= 1'b0;
        cmd_word  <= ~cmd_word;
        if (!resetn) begin
            wait_reg <= 3'h0;
            cmd_word <= 24'h000000;
        end else if (send) begin
            hold_reg <= word;
            wait_reg <= {1'b1, lag};
        end else if (wait_reg == 3'h4) begin
            cmd_valid <= 1'b1;
            cmd_word  <= hold_reg;
            wait_reg  <= 3'h0;
        end else if (wait_reg[2]) begin
            wait_reg <= wait_reg - 3'h1;
        end
    end
endmodule
`default_nettype wire

// ==== tb/test_qdlpc_top.sv ====
// Bench: random command traffic against a channel model, compared after every command except the software reset.
// Assumes qdlpc_pkg, the design and the host model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_qdlpc_top
    import qdlpc_pkg::*;
;
    logic             clk    = 1'b0;
    logic             resetn = 1'b0;
    logic             send   = 1'b0;
    logic [1:0]       lag    = 2'h0;
    logic [CMD_W-1:0] word   = 24'h000000;
    logic             strobe = 1'b1;
    logic             hw_n   = 1'b1;
    logic             rsel   = 1'b1;
    logic             cmd_valid, ref_off, por_busy;
    logic [CMD_W-1:0] cmd_word;
    logic [63:0]      out_code, in_code;
    logic [7:0]       pmode, mode_m;
    logic [3:0]       mask, mask_m;
    logic             ref_m;
    logic [15:0]      om [4];
    logic [15:0]      im [4];
    int               err_total, checks_done, cycles;

    always #2 clk = ~clk;

    qdlpc_host u_qdlpc_host (.clk(clk), .resetn(resetn), .send(send), .lag(lag), .word(word),
        .cmd_valid(cmd_valid), .cmd_word(cmd_word));
    qdlpc_top u_qdlpc_top (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
        .load_strobe_pin(strobe), .hw_reset_n_pin(hw_n), .reset_level_select(rsel),
        .out_code(out_code), .in_code(in_code), .channel_power_mode(pmode),
        .load_strobe_mask(mask), .reference_off(ref_off), .por_busy(por_busy));

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Settled outputs against the model, one step after the edge
    task automatic check();
        #1;
        chk(out_code, {om[3], om[2], om[1], om[0]});
        chk(in_code, {im[3], im[2], im[1], im[0]});
        chk(64'(pmode), 64'(mode_m));
        chk(64'(mask), 64'(mask_m));
        chk(64'(ref_off), 64'(ref_m));
    endtask

    // One command through the host; data commands refused while the clear pin is low
    task automatic cmd(input logic [3:0] c, input logic [3:0] s, input logic [15:0] d);
        logic [1:0] l;
        l = 2'($urandom);
        @(posedge clk);
        send <= 1'b1;
        lag  <= l;
        word <= {c, s, d};
        @(posedge clk);
        send <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (s[i] && hw_n && (c == 4'h1 || c == 4'h3))
                im[i] = d;
            if (s[i] && hw_n && (c == 4'h3 || (c == 4'h1 && !strobe)))
                om[i] = d;
            if (s[i] && hw_n && c == 4'h2)
                om[i] = im[i];
        end
        if (c == 4'h4)
            mode_m = d[7:0];
        if (c == 4'h5)
            mask_m = d[3:0];
        if (c == 4'h7)
            ref_m = d[0];
        repeat (5 + l) @(posedge clk);
        if (c != 4'h6)
            check();
    endtask

    // Strobe falls and stays low; masked channels keep their outputs
    task automatic fall();
        @(posedge clk);
        strobe <= 1'b0;
        for (int i = 0; i < 4; i++)
            if (!mask_m[i])
                om[i] = im[i];
        repeat (4) @(posedge clk);
        check();
    endtask

    // Bounded wait for the power-on sequence, then the power-on state
    task automatic wait_por();
        int n;
        n = 0;
        @(posedge clk);
        #1;
        chk(64'(por_busy), 64'h1);
        while (por_busy !== 1'b0 && n < 64) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 64)
            err_total++;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            om[i] = rsel ? MID_CODE : ZERO_CODE;
            im[i] = om[i];
        end
        mode_m = MODE_RST;
        mask_m = MASK_RST;
        ref_m  = REF_RST;
        check();
    endtask

    // Hang guard well above the expected run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_total++;
            end_of_test();
        end
    end

    initial begin
        void'($urandom(32'h2d721417));
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        wait_por();
        for (int k = 0; k < 6; k++)
            cmd(4'h3, 4'($urandom), 16'($urandom));
        // Partial mask, deferred load, then strobe held low over a write
        cmd(4'h5, 4'($urandom), {12'($urandom), 4'h5});
        cmd(4'h1, 4'hF, 16'($urandom));
        fall();
        cmd(4'h1, 4'hF, 16'($urandom));
        @(posedge clk);
        strobe <= 1'b1;
        cmd(4'h1, 4'($urandom), 16'($urandom));
        cmd(4'h2, 4'($urandom) | 4'h2, 16'($urandom));
        for (int k = 0; k < 3; k++)
            cmd(4'h4, 4'($urandom), 16'($urandom));
        cmd(4'h3, 4'hF, 16'($urandom));
        cmd(4'h7, 4'($urandom), 16'($urandom) & 16'hFFFE);
        cmd(4'h7, 4'($urandom), 16'($urandom) | 16'h0001);
        for (int k = 0; k < 9; k++)
            cmd(k == 0 ? 4'h0 : 4'(k + 7), 4'($urandom), 16'($urandom));
        // Hardware clear, write refused meanwhile, value kept after release
        @(posedge clk);
        hw_n <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            om[i] = MID_CODE;
            im[i] = MID_CODE;
        end
        repeat (3) @(posedge clk);
        check();
        cmd(4'h3, 4'hF, 16'($urandom));
        @(posedge clk);
        hw_n <= 1'b1;
        repeat (4) @(posedge clk);
        check();
        // Software reset to zero scale; pin activity during it is ignored
        @(posedge clk);
        rsel <= 1'b0;
        cmd(4'h6, 4'($urandom), 16'($urandom));
        strobe <= 1'b0;
        hw_n   <= 1'b0;
        repeat (2) @(posedge clk);
        strobe <= 1'b1;
        hw_n   <= 1'b1;
        wait_por();
        end_of_test();
    end
endmodule
`default_nettype wire
